// *** rtl/pcs_map.vh ***
`ifndef PCS_MAP_VH
`define PCS_MAP_VH
// Clock rate in kHz
`define PCS_CLK_KHZ 40000
// Nominal times in microseconds
`define PCS_T_100MS_US 100000
`define PCS_T_50MS_US 50000
`define PCS_T_25MS_US 25000
`define PCS_T_12P5MS_US 12500
`define PCS_T_1P5MS_US 1500
`define PCS_T_200MS_US 200000
`define PCS_T_CFG_WR_US 10000
`define PCS_T_EE_WR_US 5000
// Microseconds times percent back to milliseconds of kHz cycles
`define PCS_US_PCT_DIV 100000
// Variant scaling in percent of nominal
`define PCS_SCALE_NOM 100
`define PCS_SCALE_FAST 80
`define PCS_SCALE_SLOW 160
// Variant codes
`define PCS_VAR_NOM 2'h0
`define PCS_VAR_FAST 2'h1
`define PCS_VAR_SLOW 2'h2
// Debounce select codes
`define PCS_DB_100 2'h0
`define PCS_DB_50 2'h1
`define PCS_DB_25 2'h2
`define PCS_DB_OFF 2'h3
// Position delay select codes
`define PCS_DLY_50 2'h0
`define PCS_DLY_25 2'h1
`define PCS_DLY_12P5 2'h2
`define PCS_DLY_1P5 2'h3
// Termination period select codes
`define PCS_TERM_OFF 2'h0
`define PCS_TERM_50 2'h1
`define PCS_TERM_100 2'h2
`define PCS_TERM_200 2'h3
// Start source select codes
`define PCS_SRC_AUTO 2'h0
`define PCS_SRC_CMD 2'h1
`define PCS_SRC_PIN 2'h2
// Sizes
`define PCS_NCH 4
`define PCS_LAST_POS 2'h3
`define PCS_CNT_W 24
`endif

// *** rtl/pcs_timer.v ***
`timescale 1ns/1ps
`default_nettype none
// Down counter: load a cycle count, pulse done when it runs out
module pcs_timer (
    input wire clk, // 40 MHz clock
    input wire rst_b, // Async reset, active low
    input wire load, // Start or restart the count
    input wire stop, // Abandon the count
    input wire [23:0] count, // Cycles to count
    output reg busy_ff, // Count running
    output reg done_ff // One-cycle pulse at expiry
);
    reg [23:0] cnt_ff;

    // Load wins over stop so a restart is never lost
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 24'h000000;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (load) begin
                cnt_ff <= count;
                busy_ff <= 1'b1;
            end else if (stop) begin
                busy_ff <= 1'b0;
            end else if (busy_ff) begin
                if (cnt_ff <= 24'h000001) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff - 24'h000001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/pcs_sequencer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.vh"
module pcs_sequencer (
    input wire clk, // 40 MHz clock
    input wire rst_b, // Async reset, active low
    input wire [1:0] variant, // Timing variant code
    input wire [1:0] start_src, // Sequence start source
    input wire power_on_cmd, // Volatile power-on command pulse
    input wire power_enable_input, // Power enable pin, active high
    input wire pin_edge_mode, // 1: rising edge start, 0: level
    input wire push_button, // Pin acts as push-button
    input wire [1:0] debounce_sel, // Debounce period select
    input wire [3:0] enable_from_pin, // Per channel: enable from pin
    input wire [3:0] enable_default, // Enable register value after reset
    input wire enable_wr, // Write strobe for enable register
    input wire [3:0] enable_wdata, // Enable register write data
    input wire [7:0] position_cfg, // Two bits of position per channel
    input wire [7:0] delay_cfg, // Two bits of delay per position
    input wire [1:0] term_sel, // Termination period select
    input wire [3:0] above_ref, // Channel output exceeds reference
    input wire undervoltage_lockout, // Battery supply below lockout
    input wire [3:0] duty_cfg, // Per channel 1: 100% mode, 0: 0% mode
    input wire cfg_wr, // Configuration register write pulse
    input wire ee_wr, // Memory array write pulse
    output reg [3:0] ch_on_ff, // Channel drive enables
    output reg [3:0] duty_100_ff, // Per channel 100% duty mode
    output reg [3:0] enable_reg_ff, // Enable register contents
    output reg [1:0] position_ff, // Current sequence position
    output reg seq_done_ff, // Sequencing complete
    output reg force_shutdown_ff, // Termination timer shut down channels
    output wire write_busy // Configuration or memory write in progress
);
    localparam ST_IDLE = 4'h1;
    localparam ST_DELAY = 4'h2;
    localparam ST_RAMP = 4'h4;
    localparam ST_DONE = 4'h8;

    // Scale a microsecond figure to cycles for the variant
    function [23:0] cyc;
        input [31:0] us;
        input [1:0] v;
        reg [63:0] p;
        begin
            p = 64'h0;
            case (v)
                `PCS_VAR_FAST: p = us * `PCS_CLK_KHZ * `PCS_SCALE_FAST;
                `PCS_VAR_SLOW: p = us * `PCS_CLK_KHZ * `PCS_SCALE_SLOW;
                default: p = us * `PCS_CLK_KHZ * `PCS_SCALE_NOM;
            endcase
            p = p / `PCS_US_PCT_DIV;
            cyc = (p == 64'h0) ? 24'h000001 : p[23:0];
        end
    endfunction

    // Channels sitting at a given position
    function [3:0] at_pos;
        input [7:0] cfg;
        input [1:0] pos;
        integer i;
        begin
            at_pos = 4'h0;
            for (i = 0; i < `PCS_NCH; i = i + 1) begin
                if (cfg[2*i +: 2] == pos)
                    at_pos[i] = 1'b1;
            end
        end
    endfunction

    reg [3:0] state_ff, nxt_state;
    reg [1:0] nxt_position;
    reg pin_prev_ff, pin_db_ff, started_ff;
    reg [23:0] db_cnt_ff;
    wire [3:0] ch_en;
    wire [3:0] pos_set;
    wire [3:0] pos_en;
    wire dly_done, term_done, wr_busy_t;
    reg dly_load, dly_stop;
    reg [23:0] dly_cnt, db_len, term_cnt;
    wire start_req;
    wire pin_rise;
    wire pb_release;

    // Debounce length from select
    always @* begin
        case (debounce_sel)
            `PCS_DB_100: db_len = cyc(`PCS_T_100MS_US, variant);
            `PCS_DB_50: db_len = cyc(`PCS_T_50MS_US, variant);
            `PCS_DB_25: db_len = cyc(`PCS_T_25MS_US, variant);
            default: db_len = 24'h000000;
        endcase
    end

    // Pin must stay at a new level for the full period before it counts
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_db_ff <= 1'b0;
            db_cnt_ff <= 24'h000000;
            pin_prev_ff <= 1'b0;
        end else begin
            pin_prev_ff <= pin_db_ff;
            if (debounce_sel == `PCS_DB_OFF) begin
                pin_db_ff <= power_enable_input;
            end else if (power_enable_input == pin_db_ff) begin
                db_cnt_ff <= 24'h000000;
            end else if (db_cnt_ff + 24'h000001 >= db_len) begin
                pin_db_ff <= power_enable_input;
                db_cnt_ff <= 24'h000000;
            end else begin
                db_cnt_ff <= db_cnt_ff + 24'h000001;
            end
        end
    end

    assign pin_rise = pin_db_ff & ~pin_prev_ff;
    // Start request by source; edge mode needs a fresh rise
    assign start_req = (start_src == `PCS_SRC_AUTO) ? 1'b1 :
        (start_src == `PCS_SRC_CMD) ? power_on_cmd :
        (start_src == `PCS_SRC_PIN) ? (pin_edge_mode ? pin_rise : pin_db_ff) : 1'b0;
    // Button let go for the debounce period turns everything off
    assign pb_release = push_button && (start_src == `PCS_SRC_PIN) && !pin_db_ff;

    // Enable register: cleared at reset, default on the first edge after, software writes after
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_reg_ff <= 4'h0;
            started_ff <= 1'b0;
        end else begin
            started_ff <= 1'b1;
            if (!started_ff)
                enable_reg_ff <= enable_default;
            else if (enable_wr)
                enable_reg_ff <= enable_wdata;
        end
    end

    // Per channel enable source
    assign ch_en = (enable_from_pin & {`PCS_NCH{pin_db_ff}}) | (~enable_from_pin & enable_reg_ff);
    assign pos_set = at_pos(position_cfg, position_ff);
    assign pos_en = pos_set & ch_en;

    // Position delay from per-position select
    always @* begin
        case (delay_cfg[2*nxt_position +: 2])
            `PCS_DLY_50: dly_cnt = cyc(`PCS_T_50MS_US, variant);
            `PCS_DLY_25: dly_cnt = cyc(`PCS_T_25MS_US, variant);
            `PCS_DLY_12P5: dly_cnt = cyc(`PCS_T_12P5MS_US, variant);
            default: dly_cnt = cyc(`PCS_T_1P5MS_US, variant);
        endcase
    end

    // Termination period
    always @* begin
        case (term_sel)
            `PCS_TERM_50: term_cnt = cyc(`PCS_T_50MS_US, variant);
            `PCS_TERM_100: term_cnt = cyc(`PCS_T_100MS_US, variant);
            `PCS_TERM_200: term_cnt = cyc(`PCS_T_200MS_US, variant);
            default: term_cnt = 24'h000001;
        endcase
    end

    // Sequencer; a position with no enabled channels still waits out its delay
    always @* begin
        nxt_state = state_ff;
        nxt_position = position_ff;
        dly_load = 1'b0;
        dly_stop = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                nxt_position = 2'h0;
                if (start_req && !undervoltage_lockout && !force_shutdown_ff) begin
                    nxt_state = ST_DELAY;
                    dly_load = 1'b1;
                end
            end
            ST_DELAY: begin
                if (dly_done)
                    nxt_state = ST_RAMP;
            end
            ST_RAMP: begin
                if ((pos_en & ~above_ref) == 4'h0) begin
                    if (position_ff == `PCS_LAST_POS) begin
                        nxt_state = ST_DONE;
                    end else begin
                        nxt_position = position_ff + 2'h1;
                        nxt_state = ST_DELAY;
                        dly_load = 1'b1;
                    end
                end
            end
            ST_DONE: begin
                nxt_state = ST_DONE;
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (force_shutdown_ff || term_done || undervoltage_lockout || pb_release) begin
            nxt_state = ST_IDLE;
            dly_stop = 1'b1;
            dly_load = 1'b0;
        end
    end

    // State, channel drive and flags; lockout or expiry drops all channels
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            position_ff <= 2'h0;
            ch_on_ff <= 4'h0;
            seq_done_ff <= 1'b0;
            force_shutdown_ff <= 1'b0;
            duty_100_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            position_ff <= nxt_position;
            duty_100_ff <= duty_cfg;
            seq_done_ff <= (nxt_state == ST_DONE);
            if (term_done)
                force_shutdown_ff <= 1'b1;
            else if (!start_req)
                force_shutdown_ff <= 1'b0;
            if (undervoltage_lockout || term_done || force_shutdown_ff || pb_release)
                ch_on_ff <= 4'h0;
            else if (state_ff == ST_IDLE && !start_req)
                ch_on_ff <= 4'h0;
            else if (state_ff == ST_DELAY && dly_done)
                ch_on_ff <= ch_on_ff | pos_en;
            else
                ch_on_ff <= ch_on_ff & ch_en;
        end
    end

    pcs_timer u_dly (
        .clk(clk),
        .rst_b(rst_b),
        .load(dly_load),
        .stop(dly_stop),
        .count(dly_cnt),
        .busy_ff(),
        .done_ff(dly_done)
    );

    // Termination timer restarts as each position's delay expires
    pcs_timer u_term (
        .clk(clk),
        .rst_b(rst_b),
        .load((state_ff == ST_DELAY) && dly_done && (term_sel != `PCS_TERM_OFF)),
        .stop(nxt_state != ST_RAMP),
        .count(term_cnt),
        .busy_ff(),
        .done_ff(term_done)
    );

    // Write busy window; the longer config time wins when both start
    pcs_timer u_wr (
        .clk(clk),
        .rst_b(rst_b),
        .load(cfg_wr | ee_wr),
        .stop(1'b0),
        .count(cfg_wr ? cyc(`PCS_T_CFG_WR_US, variant) : cyc(`PCS_T_EE_WR_US, variant)),
        .busy_ff(wr_busy_t),
        .done_ff()
    );
    assign write_busy = wr_busy_t;
endmodule
`default_nettype wire

// *** testbench/pcs_sequencer_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.vh"
module pcs_sequencer_chk (
    input wire logic clk, // Sequencer clock
    input wire logic rst_b, // Async reset, active low
    input wire logic undervoltage_lockout, // Supply lockout
    input wire logic [3:0] duty_cfg, // Duty mode request
    input wire logic [3:0] duty_100_ff, // Duty mode applied
    input wire logic enable_wr, // Enable register strobe
    input wire logic [3:0] enable_wdata, // Enable register data
    input wire logic [3:0] enable_reg_ff, // Enable register
    input wire logic [3:0] enable_from_pin, // Pin sourcing per channel
    input wire logic [1:0] position_ff, // Sequence position
    input wire logic cfg_wr, // Config write pulse
    input wire logic ee_wr, // Memory write pulse
    input wire logic write_busy, // Write in progress
    input wire logic [1:0] start_src, // Start source select
    input wire logic push_button, // Pin acts as push-button
    input wire logic [1:0] debounce_sel, // Debounce select
    input wire logic power_enable_input, // Power enable pin
    input wire logic [3:0] ch_on_ff // Channel drives
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Lockout drops every drive by the next edge
    property p_lock_off;
        undervoltage_lockout |=> ch_on_ff == 4'h0;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("drive kept during lockout");
    // No drive may rise from an edge that saw lockout
    property p_lock_rise;
        (ch_on_ff & ~$past(ch_on_ff)) != 4'h0 |-> !$past(undervoltage_lockout);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("drive rose under lockout");
    property p_duty;
        1'b1 |=> duty_100_ff == $past(duty_cfg);
    endproperty
    a_duty: assert property (p_duty) else $error("duty mode not applied");
    property p_en_write;
        enable_wr |=> enable_reg_ff == $past(enable_wdata);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost");
    // Past the default load, only a write may move the register
    property p_en_hold;
        !$past(enable_wr) && $past(rst_b, 2) |-> $stable(enable_reg_ff);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable register moved");
    // Position counter only steps by one or returns to 0
    property p_step;
        position_ff != $past(position_ff) && position_ff != 2'h0 |-> position_ff == $past(position_ff) + 2'h1;
    endproperty
    a_step: assert property (p_step) else $error("position jumped");
    property p_busy;
        cfg_wr || ee_wr |=> write_busy [*8];
    endproperty
    a_busy: assert property (p_busy) else $error("write busy missing");
    // A drive rises only for a channel that has an enable source
    property p_ch_src;
        (ch_on_ff & ~$past(ch_on_ff) & ~$past(enable_reg_ff) & ~$past(enable_from_pin)) == 4'h0;
    endproperty
    a_ch_src: assert property (p_ch_src) else $error("drive without enable");
    // Undebounced button low: one edge to latch the pin, one to drop drives
    property p_pb_off;
        push_button && start_src == `PCS_SRC_PIN && debounce_sel == `PCS_DB_OFF && !power_enable_input
            |-> ##2 ch_on_ff == 4'h0;
    endproperty
    a_pb_off: assert property (p_pb_off) else $error("drive kept after button release");
    c_ch_on: cover property (ch_on_ff != 4'h0);
    c_step: cover property (position_ff != $past(position_ff));
    c_busy: cover property ($rose(write_busy));
endmodule
bind pcs_sequencer pcs_sequencer_chk pcs_sequencer_chk_i (
    .clk(clk),
    .rst_b(rst_b),
    .undervoltage_lockout(undervoltage_lockout),
    .duty_cfg(duty_cfg),
    .duty_100_ff(duty_100_ff),
    .enable_wr(enable_wr),
    .enable_wdata(enable_wdata),
    .enable_reg_ff(enable_reg_ff),
    .enable_from_pin(enable_from_pin),
    .position_ff(position_ff),
    .cfg_wr(cfg_wr),
    .ee_wr(ee_wr),
    .write_busy(write_busy),
    .start_src(start_src),
    .push_button(push_button),
    .debounce_sel(debounce_sel),
    .power_enable_input(power_enable_input),
    .ch_on_ff(ch_on_ff)
);
`default_nettype wire

// *** testbench/pcs_rail_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Rails ramp a few cycles after their drive, collapse at once when it drops
module pcs_rail_model #(
    parameter int RAMP = 8
) (
    input wire logic clk, // Sequencer clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [3:0] ch_on, // Drive enables
    output logic [3:0] above_ref // Rail past its reference
);
    logic [4*RAMP-1:0] hist_ff;
    // Delay line stands in for the soft-start ramp
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hist_ff <= '0;
        end else begin
            hist_ff <= {hist_ff[4*RAMP-5:0], ch_on};
        end
    end
    assign above_ref = hist_ff[4*RAMP-1 -: 4] & ch_on;
endmodule
`default_nettype wire

// *** testbench/pcs_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.vh"
module pcs_sequencer_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] variant = `PCS_VAR_FAST;
    logic [1:0] start_src = 2'h3;
    logic power_on_cmd = 1'b0;
    logic power_enable_input = 1'b0;
    logic pin_edge_mode = 1'b0;
    logic push_button = 1'b0;
    logic [1:0] debounce_sel = `PCS_DB_OFF;
    logic [3:0] enable_from_pin = 4'h0;
    logic [3:0] enable_default = 4'h0;
    logic enable_wr = 1'b0;
    logic [3:0] enable_wdata = 4'h0;
    logic [7:0] position_cfg = 8'h00;
    logic [7:0] delay_cfg = 8'hff;
    logic [1:0] term_sel = `PCS_TERM_OFF;
    logic [3:0] above_ref;
    logic undervoltage_lockout = 1'b0;
    logic [3:0] duty_cfg = 4'h0;
    logic cfg_wr = 1'b0;
    logic ee_wr = 1'b0;
    logic [3:0] ch_on_ff;
    logic [3:0] duty_100_ff;
    logic [3:0] enable_reg_ff;
    logic [1:0] position_ff;
    logic seq_done_ff;
    logic force_shutdown_ff;
    logic write_busy;
    int failures = 0;
    int checks_done = 0;
    int n;
    int dly;
    pcs_sequencer pcs_sequencer_i (.clk(clk), .rst_b(rst_b), .variant(variant), .start_src(start_src),
        .power_on_cmd(power_on_cmd), .power_enable_input(power_enable_input), .pin_edge_mode(pin_edge_mode),
        .push_button(push_button), .debounce_sel(debounce_sel), .enable_from_pin(enable_from_pin),
        .enable_default(enable_default), .enable_wr(enable_wr), .enable_wdata(enable_wdata),
        .position_cfg(position_cfg), .delay_cfg(delay_cfg), .term_sel(term_sel), .above_ref(above_ref),
        .undervoltage_lockout(undervoltage_lockout), .duty_cfg(duty_cfg), .cfg_wr(cfg_wr), .ee_wr(ee_wr),
        .ch_on_ff(ch_on_ff), .duty_100_ff(duty_100_ff), .enable_reg_ff(enable_reg_ff),
        .position_ff(position_ff), .seq_done_ff(seq_done_ff), .force_shutdown_ff(force_shutdown_ff),
        .write_busy(write_busy));
    pcs_rail_model pcs_rail_model_i (.clk(clk), .rst_b(rst_b), .ch_on(ch_on_ff), .above_ref(above_ref));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Scaled period in cycles for a nominal time in microseconds
    function automatic int cycles_of(input int us, input int pct);
        return us * (`PCS_CLK_KHZ / 1000) * pct / 100;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One-cycle pulse, launched and ended on falling edges
    task automatic pulse(ref logic sig);
        @(negedge clk);
        sig = 1'b1;
        @(negedge clk);
        sig = 1'b0;
    endtask
    // Bounded wait for any drive; a spent bound ends the run
    task automatic wait_drive(input int limit);
        n = 0;
        while (ch_on_ff === 4'h0 && n < limit) begin
            @(negedge clk);
            n++;
        end
        if (n >= limit) begin
            failures++;
            end_of_test();
        end
    endtask
    initial begin
        void'($urandom(32'h6c70));
        enable_default = 4'($urandom());
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        check(enable_reg_ff, enable_default);
        check(ch_on_ff, 4'h0);
        // Random duty modes and register writes, ending on a partial mask
        for (int i = 0; i < 8; i++) begin
            duty_cfg = 4'($urandom());
            enable_from_pin = 4'($urandom());
            power_enable_input = 1'($urandom());
            enable_wdata = (i == 7) ? 4'hb : 4'($urandom());
            enable_wr = 1'b1;
            @(negedge clk);
            enable_wr = 1'b0;
            check(duty_100_ff, duty_cfg);
            check(enable_reg_ff, enable_wdata);
            @(negedge clk);
        end
        enable_from_pin = 4'h0;
        // Command refused while the supply is locked out
        undervoltage_lockout = 1'b1;
        start_src = `PCS_SRC_CMD;
        pulse(power_on_cmd);
        pulse(cfg_wr);
        check(write_busy, 1'b1);
        repeat (1000) @(negedge clk);
        check(write_busy, 1'b1);
        pulse(ee_wr);
        check(ch_on_ff, 4'h0);
        check(position_ff, 2'h0);
        undervoltage_lockout = 1'b0;
        // Full start: all channels in position 0 with the shortest delay
        dly = cycles_of(`PCS_T_1P5MS_US, `PCS_SCALE_FAST);
        pulse(power_on_cmd);
        wait_drive(dly + 50);
        check(n >= dly - 1 && n <= dly + 3, 1'b1);
        check(ch_on_ff, 4'hb);
        n = 0;
        while (position_ff === 2'h0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(position_ff !== 2'h0, 1'b1);
        check(seq_done_ff, 1'b0);
        check(force_shutdown_ff, 1'b0);
        undervoltage_lockout = 1'b1;
        repeat (2) @(negedge clk);
        check(ch_on_ff, 4'h0);
        // Push-button start on a fresh pin rise, then release drops all drives
        undervoltage_lockout = 1'b0;
        start_src = `PCS_SRC_PIN;
        push_button = 1'b1;
        pin_edge_mode = 1'b1;
        power_enable_input = 1'b0;
        repeat (2) @(negedge clk);
        power_enable_input = 1'b1;
        wait_drive(dly + 50);
        check(n >= dly && n <= dly + 4, 1'b1);
        check(ch_on_ff, 4'hb);
        power_enable_input = 1'b0;
        repeat (2) @(negedge clk);
        check(ch_on_ff, 4'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
